// *** hdl/periph_irq_flag_enable_priority.sv ***
// Purpose: Peripheral interrupt flags, enables and priorities, with the
//          high and low priority requests to the core.
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, 8-bit registers
//          in byte lane 0; event inputs are one-cycle pulses or levels.
// Notes:   Every access takes one wait cycle; unmapped reads return zero.
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "periph_irq_regs.svh"

// How it works
// (RULE_01) Oscillator failure sets bit 7 of flags b until software clears.
// (RULE_02) Any comparator input change sets bit 6, held until cleared.
// (RULE_03) Bit 5 of flags b, enable b, priority b always reads zero.
// (RULE_04) Nonvolatile write completion sets bit 4; only software clears.
// (RULE_05) Serial bus collision sets bit 3 until software clears it.
// (RULE_06) Low supply detection sets bit 2 until software clears it.
// (RULE_07) Timer 3 overflow sets bit 1 until software clears it.
// (RULE_08) In capture mode a timer capture sets bit 0, held until cleared.
// (RULE_09) In compare mode a match sets bit 0; PWM mode never sets it.
// (RULE_10) Without priority levels the peripheral global enable also gates.
// (RULE_11) Priority bits steer requests only while priority levels are on.
// (RULE_12) Each enable a bit gates its matching bank a source.
// (RULE_13) Each enable b bit gates the matching flags b bit.
// (RULE_14) Priority a bits: one high, zero low; all reset to one.
// (RULE_15) Implemented priority b bits: one high, zero low; reset to one.
// (RULE_16) Software keeps the parallel port enable zero on small packages.
// (RULE_17) Software keeps the parallel port priority one on small packages.
// (RULE_18) Priority levels switch lives in the reset cause register.
// (RULE_19) Flags set regardless of individual or global enable state.
// (RULE_20) With levels on, low enable gates low, high enable gates high.
// (RULE_21) Each request is OR of flag, enable, priority, then group gated.
// (RULE_22) Writing zero clears a flag; a same-cycle hardware set wins.
module periph_irq_flag_enable_priority (
  input  wire logic                        clk_sys_in,
  input  wire logic                        srst_in,
  // Avalon-MM slave
  input  wire logic [`IRQ_ADDR_W-1:0]      avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [31:0]                 avs_writedata_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  output logic      [31:0]                 avs_readdata_out,
  output logic                             avs_waitrequest_out,
  // First-bank flags, owned by the peripherals themselves
  input  wire logic [7:0]                  first_flags_in,
  // Second-bank events
  input  wire logic                        osc_fail_in,
  input  wire logic                        comparator_change_in,
  input  wire logic                        nv_write_done_in,
  input  wire logic                        bus_collision_in,
  input  wire logic                        low_voltage_in,
  input  wire logic                        timer3_overflow_in,
  input  wire logic                        capcmp2_capture_in,
  input  wire logic                        capcmp2_match_in,
  input  wire periph_irq_pkg::capcmp_mode_t capcmp2_mode_in,
  // Reset and wake-up cause bits kept by the reset block
  input  wire logic [`CAUSE_W-1:0]         reset_cause_in,
  // Core global enables
  input  wire logic                        high_group_enable_in,
  input  wire logic                        low_group_enable_in,
  // Requests to the core
  output logic                             high_request_out,
  output logic                             low_request_out,
  output logic                             priority_levels_on_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // OR over sources of flag, enable and wanted priority
  function automatic logic any_request(
    input periph_irq_pkg::irq_byte_t flags,
    input periph_irq_pkg::irq_byte_t enables,
    input periph_irq_pkg::irq_byte_t prio_sel
  );
    any_request = |(flags & enables & prio_sel);
  endfunction : any_request

  // Byte address decode for one register
  function automatic logic addr_hit(
    input logic [`IRQ_ADDR_W-1:0] addr,
    input logic [`IRQ_ADDR_W-1:0] offset
  );
    addr_hit = (addr == offset);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  periph_irq_pkg::irq_byte_t flags_b;
  periph_irq_pkg::irq_byte_t enable_a;
  periph_irq_pkg::irq_byte_t enable_b;
  periph_irq_pkg::irq_byte_t priority_a;
  periph_irq_pkg::irq_byte_t priority_b;
  logic                      priority_levels_on;

  periph_irq_pkg::irq_byte_t next_enable_a;
  periph_irq_pkg::irq_byte_t next_enable_b;
  periph_irq_pkg::irq_byte_t next_priority_a;
  periph_irq_pkg::irq_byte_t next_priority_b;
  logic                      next_priority_levels_on;
  logic                      next_waitrequest;
  periph_irq_pkg::bus_word_t next_readdata;
  logic                      next_high_request;
  logic                      next_low_request;

  periph_irq_pkg::irq_byte_t flag_set_b;
  periph_irq_pkg::irq_byte_t wr_byte;
  periph_irq_pkg::irq_byte_t read_byte;
  periph_irq_pkg::irq_byte_t first_flags;
  logic                      capture_set;
  logic                      compare_set;
  logic                      access_req;
  logic                      commit;
  logic                      wr_commit;
  logic                      hit_flags_b;
  logic                      hit_enable_a;
  logic                      hit_enable_b;
  logic                      hit_priority_a;
  logic                      hit_priority_b;
  logic                      hit_reset_cause;
  logic                      hit_flags_a;
  logic                      wr_flags_b;
  logic                      pend_any_a;
  logic                      pend_any_b;
  logic                      pend_high;
  logic                      pend_low;
  logic                      compat_request;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // A request is answered once: the edge after it is seen, waitrequest
  // drops for one cycle and the access commits at the edge that samples it
  assign access_req       = avs_read_in | avs_write_in;
  assign next_waitrequest = ~(access_req & avs_waitrequest_out);
  assign commit           = access_req & ~avs_waitrequest_out;

  // Writes only land through byte lane 0, where the 8-bit data sits
  assign wr_commit = commit & avs_write_in & avs_byteenable_in[0];
  assign wr_byte   = avs_writedata_in[7:0];

  // Address decode
  assign hit_flags_b     = addr_hit(avs_address_in, `OFS_FLAGS_B);
  assign hit_enable_a    = addr_hit(avs_address_in, `OFS_ENABLE_A);
  assign hit_enable_b    = addr_hit(avs_address_in, `OFS_ENABLE_B);
  assign hit_priority_a  = addr_hit(avs_address_in, `OFS_PRIORITY_A);
  assign hit_priority_b  = addr_hit(avs_address_in, `OFS_PRIORITY_B);
  assign hit_reset_cause = addr_hit(avs_address_in, `OFS_RESET_CAUSE);
  assign hit_flags_a     = addr_hit(avs_address_in, `OFS_FLAGS_A);

  ////////////////////////////////////////////////////////////////////////////
  // Second-bank event sources

  // Capture/compare 2 sets on capture or match only in its own mode;
  // PWM and off modes leave the flag alone
  assign capture_set = (capcmp2_mode_in == periph_irq_pkg::CAPCMP_CAPTURE)
                       & capcmp2_capture_in;                  // [RULE_08]
  assign compare_set = (capcmp2_mode_in == periph_irq_pkg::CAPCMP_COMPARE)
                       & capcmp2_match_in;                    // [RULE_09]

  // Set vector; independent of any enable so software may poll [RULE_19]
  always_comb begin
    flag_set_b = `RST_FLAGS;
    flag_set_b[`BIT_OSC_FAIL]      = osc_fail_in;             // [RULE_01]
    flag_set_b[`BIT_COMPARATOR]    = comparator_change_in;    // [RULE_02]
    flag_set_b[`BIT_NV_WRITE_DONE] = nv_write_done_in;        // [RULE_04]
    flag_set_b[`BIT_BUS_COLLISION] = bus_collision_in;        // [RULE_05]
    flag_set_b[`BIT_LOW_VOLTAGE]   = low_voltage_in;          // [RULE_06]
    flag_set_b[`BIT_TIMER3_OVF]    = timer3_overflow_in;      // [RULE_07]
    flag_set_b[`BIT_CAPCMP2]       = capture_set | compare_set;
  end

  assign wr_flags_b = wr_commit & hit_flags_b;

  // Sticky flags; a zero write clears, a same-cycle set wins   [RULE_22]
  sticky_flag_bank #(
    .WIDTH      (8),
    .IMPL       (`MASK_BANK_B),                               // [RULE_03]
    .RST_VAL    (`RST_FLAGS)
  ) u_flags_b (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .set_in     (flag_set_b),
    .wr_en_in   (wr_flags_b),
    .wr_data_in (wr_byte),
    .flags_out  (flags_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Enable, priority and control registers

  // Next values; unimplemented bits of bank b are forced to zero
  assign next_enable_a   = (wr_commit & hit_enable_a) ?
                           (wr_byte & `MASK_BANK_A) : enable_a; // [RULE_12]
  assign next_enable_b   = (wr_commit & hit_enable_b) ?
                           (wr_byte & `MASK_BANK_B) : enable_b; // [RULE_13]
  assign next_priority_a = (wr_commit & hit_priority_a) ?
                           (wr_byte & `MASK_BANK_A) : priority_a;
  assign next_priority_b = (wr_commit & hit_priority_b) ?
                           (wr_byte & `MASK_BANK_B) : priority_b; // [RULE_03]

  // Only the priority switch of the reset cause register is writable
  // here; the cause bits belong to the reset block
  assign next_priority_levels_on = (wr_commit & hit_reset_cause) ?
                                   wr_byte[`BIT_PRIO_LEVELS_ON] :
                                   priority_levels_on;        // [RULE_18]

  // Register storage; priorities reset to high             [RULE_14]
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      enable_a           <= `RST_ENABLE;
      enable_b           <= `RST_ENABLE;
      priority_a         <= `RST_PRIORITY_A;                  // [RULE_14]
      priority_b         <= `RST_PRIORITY_B;                  // [RULE_15]
      priority_levels_on <= `RST_PRIO_LEVELS_ON;
    end else begin
      enable_a           <= next_enable_a;
      enable_b           <= next_enable_b;
      priority_a         <= next_priority_a;
      priority_b         <= next_priority_b;
      priority_levels_on <= next_priority_levels_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request formation

  assign first_flags = first_flags_in;

  // Any enabled source, priority ignored, for the compatible scheme
  assign pend_any_a = any_request(first_flags, enable_a, `MASK_BANK_A);
  assign pend_any_b = any_request(flags_b, enable_b, `MASK_BANK_B);

  // Sources split by their priority bit                     [RULE_21]
  assign pend_high = any_request(first_flags, enable_a, priority_a) |
                     any_request(flags_b, enable_b, priority_b);
  assign pend_low  = any_request(first_flags, enable_a, ~priority_a) |
                     any_request(flags_b, enable_b, ~priority_b);

  // Without levels both enables must be set, on a single vector
  assign compat_request = (pend_any_a | pend_any_b) &
                          high_group_enable_in &
                          low_group_enable_in;                // [RULE_10]

  // Priority bits only matter once levels are switched on   [RULE_11]
  assign next_high_request = priority_levels_on ?
                             (pend_high & high_group_enable_in) :
                             compat_request;                  // [RULE_20]
  assign next_low_request  = priority_levels_on &
                             pend_low & low_group_enable_in;  // [RULE_20]

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Read mux; unmapped addresses read zero
  assign read_byte =
    hit_flags_b     ? flags_b    :
    hit_enable_a    ? enable_a   :
    hit_enable_b    ? enable_b   :
    hit_priority_a  ? priority_a :
    hit_priority_b  ? priority_b :
    hit_reset_cause ? {priority_levels_on, 2'h0, reset_cause_in} :
    hit_flags_a     ? first_flags :
                      8'h00;

  // Read data is captured when waitrequest drops and held after
  assign next_readdata = (access_req & avs_waitrequest_out & avs_read_in) ?
                         {24'h000000, read_byte} : avs_readdata_out;

  // Bus and request outputs, all registered
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      avs_waitrequest_out    <= 1'b1;
      avs_readdata_out       <= 32'h00000000;
      high_request_out       <= 1'b0;
      low_request_out        <= 1'b0;
      priority_levels_on_out <= `RST_PRIO_LEVELS_ON;
    end else begin
      avs_waitrequest_out    <= next_waitrequest;
      avs_readdata_out       <= next_readdata;
      high_request_out       <= next_high_request;
      low_request_out        <= next_low_request;
      priority_levels_on_out <= next_priority_levels_on;
    end
  end

endmodule : periph_irq_flag_enable_priority

// *** pkg/periph_irq_regs.svh ***
// Purpose: Offsets, field positions and reset values of the peripheral
//          interrupt bank.
// Assumes: Byte addresses on a 32-bit Avalon-MM bus, one word per register.
// Notes:   Definitions only; included by bare name.
`ifndef PERIPH_IRQ_REGS_SVH
`define PERIPH_IRQ_REGS_SVH

// Register byte offsets
`define IRQ_ADDR_W            8
`define OFS_FLAGS_B           8'h00
`define OFS_ENABLE_A          8'h04
`define OFS_ENABLE_B          8'h08
`define OFS_PRIORITY_A        8'h0c
`define OFS_PRIORITY_B        8'h10
`define OFS_RESET_CAUSE       8'h14
`define OFS_FLAGS_A           8'h18

// Second-bank field positions
`define BIT_OSC_FAIL          7
`define BIT_COMPARATOR        6
`define BIT_UNUSED_B          5
`define BIT_NV_WRITE_DONE     4
`define BIT_BUS_COLLISION     3
`define BIT_LOW_VOLTAGE       2
`define BIT_TIMER3_OVF        1
`define BIT_CAPCMP2           0

// Reset-cause register fields
`define BIT_PRIO_LEVELS_ON    7
`define CAUSE_MSB             4
`define CAUSE_W               5

// Implemented-bit masks and reset values
`define MASK_BANK_A           8'hff
`define MASK_BANK_B           8'hdf
`define RST_FLAGS             8'h00
`define RST_ENABLE            8'h00
`define RST_PRIORITY_A        8'hff
`define RST_PRIORITY_B        8'hdf
`define RST_PRIO_LEVELS_ON    1'b0

`endif

// *** pkg/periph_irq_pkg.sv ***
// Purpose: Types shared by the peripheral interrupt bank.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in periph_irq_regs.svh.
package periph_irq_pkg;

  // Operating mode of the second capture/compare unit
  typedef enum logic [1:0] {
    CAPCMP_CAPTURE,
    CAPCMP_COMPARE,
    CAPCMP_PWM,
    CAPCMP_OFF
  } capcmp_mode_t;

  typedef logic [7:0]  irq_byte_t;
  typedef logic [31:0] bus_word_t;

endpackage : periph_irq_pkg

// *** hdl/sticky_flag_bank.sv ***
// Purpose: Bank of sticky flags set by hardware and written by software.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Unimplemented bits are masked and always read zero.
`timescale 1ns/100ps

module sticky_flag_bank #(
  parameter int                    WIDTH    = 8,
  parameter logic [WIDTH-1:0]      IMPL     = '1,
  parameter logic [WIDTH-1:0]      RST_VAL  = '0
) (
  input  wire logic                clk_sys_in,
  input  wire logic                srst_in,
  input  wire logic [WIDTH-1:0]    set_in,
  input  wire logic                wr_en_in,
  input  wire logic [WIDTH-1:0]    wr_data_in,
  output logic      [WIDTH-1:0]    flags_out
);

  logic [WIDTH-1:0] next_flags;

  // A hardware set in the write cycle beats the software clear
  assign next_flags = (set_in | (wr_en_in ? wr_data_in : flags_out)) & IMPL;

  // Flag storage
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      flags_out <= RST_VAL & IMPL;
    end else begin
      flags_out <= next_flags;
    end
  end

endmodule : sticky_flag_bank

// *** dv/periph_irq_checker_asserts.sv ***
// Purpose: Port-level assertions for the peripheral interrupt bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Request checks allow up to two register stages of delay.
`timescale 1ns/100ps
`include "periph_irq_regs.svh"
module periph_irq_checker (
  input  wire logic                   clk_sys_in,
  input  wire logic                   srst_in,
  input  wire logic [`IRQ_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_readdata_out,
  input  wire logic                   avs_waitrequest_out,
  input  wire logic                   high_group_enable_in,
  input  wire logic                   low_group_enable_in,
  input  wire logic                   high_request_out,
  input  wire logic                   low_request_out,
  input  wire logic                   priority_levels_on_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic lvl_wr_d1;
  logic lvl_wr_d2;
  // Writes aimed at the switch register, and reads of bank b registers
  wire lvl_wr = avs_write_in && (avs_address_in == `OFS_RESET_CAUSE);
  wire rd_b = avs_read_in && !avs_waitrequest_out &&
    (avs_address_in == `OFS_FLAGS_B || avs_address_in == `OFS_ENABLE_B ||
     avs_address_in == `OFS_PRIORITY_B);
  // Two-deep history; the switch output changes at the same edge as its register
  always_ff @(posedge clk_sys_in) begin
    lvl_wr_d1 <= lvl_wr;
    lvl_wr_d2 <= lvl_wr_d1;
  end
  //////////////////////////////////////////////////////////////////////////
  AST_ONE_WAIT: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("Access not answered after one wait cycle");
  AST_WAIT_STANDS: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("Answer held longer than one cycle");
  AST_RD_UNUSED: assert property (rd_b |->
    !avs_readdata_out[`BIT_UNUSED_B]) else $error("Bit 5 read as one");
  AST_RD_UPPER: assert property (!avs_waitrequest_out |->
    avs_readdata_out[31:8] == 24'h0) else $error("Upper read data not zero");
  AST_LOW_OFF: assert property (
    !priority_levels_on_out [*3] |=> !low_request_out)
    else $error("Low request while priority levels off");
  AST_PERIPH_GATE: assert property (
    (!priority_levels_on_out && !low_group_enable_in) [*3]
    |=> !high_request_out) else $error("Request passed peripheral gate");
  AST_HIGH_GATE: assert property (
    !high_group_enable_in [*3] |=> !high_request_out)
    else $error("High request with high group disabled");
  AST_LOW_GATE: assert property (
    !low_group_enable_in [*3] |=> !low_request_out)
    else $error("Low request with low group disabled");
  AST_SWITCH: assert property (
    !$stable(priority_levels_on_out) |-> lvl_wr_d1 || lvl_wr_d2)
    else $error("Priority switch moved without a register write");
endmodule : periph_irq_checker

bind periph_irq_flag_enable_priority periph_irq_checker periph_irq_checker_i (
  .clk_sys_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .high_group_enable_in,
  .low_group_enable_in, .high_request_out, .low_request_out,
  .priority_levels_on_out);

// *** dv/periph_event_model.sv ***
// Purpose: Peripheral side: the modules that raise second-bank events.
// Assumes: The bench updates the command vector right after a clock edge.
// Notes:   Bit 5 carries the compare match; the rest follow flags b.
`timescale 1ns/100ps
module periph_event_model (
  input  wire logic [7:0] ev_cmd_in,
  output logic      [7:0] events_out
);
  // A line stays high as long as commanded; a held line keeps setting
  // its flag, which lets the bench collide an event with a clear
  assign events_out = ev_cmd_in;
endmodule : periph_event_model

// *** dv/periph_irq_flag_enable_priority_test.sv ***
// Purpose: Self-checking bench for the peripheral interrupt bank.
// Assumes: Bus answers come when waitrequest drops; no fixed latency.
// Notes:   Request checks allow a few cycles for the register stages.
`timescale 1ns/100ps
`include "periph_irq_regs.svh"
module periph_irq_flag_enable_priority_test;
  logic        clk_sys_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr_s = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] rdat;
  logic [31:0] got_q;
  logic        wreq, hi_req, lo_req, lvl_on;
  logic [7:0]  first_flags = 8'h00;
  logic [7:0]  ev_cmd = 8'h00;
  logic [7:0]  pin;
  logic        hi_en = 1'b0;
  logic        lo_en = 1'b0;
  logic [4:0]  cause = 5'h1a;
  periph_irq_pkg::capcmp_mode_t mode = periph_irq_pkg::CAPCMP_CAPTURE;
  int          errors = 0;
  int          n_checks = 0;
  int          bits [6] = '{7, 6, 4, 3, 2, 1};
  // 200 MHz system clock
  always #2.5 clk_sys_in = ~clk_sys_in;
  periph_event_model periph_event_model_i (.ev_cmd_in(ev_cmd),
    .events_out(pin));
  periph_irq_flag_enable_priority periph_irq_flag_enable_priority_i (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr_s), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .first_flags_in(first_flags),
    .osc_fail_in(pin[7]), .comparator_change_in(pin[6]),
    .nv_write_done_in(pin[4]), .bus_collision_in(pin[3]),
    .low_voltage_in(pin[2]), .timer3_overflow_in(pin[1]),
    .capcmp2_capture_in(pin[0]), .capcmp2_match_in(pin[5]),
    .capcmp2_mode_in(mode), .reset_cause_in(cause),
    .high_group_enable_in(hi_en), .low_group_enable_in(lo_en),
    .high_request_out(hi_req), .low_request_out(lo_req),
    .priority_levels_on_out(lvl_on));
  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One bus access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     input logic [7:0] ev);
    int n;
    @(posedge clk_sys_in);
    adr <= a;
    wdat <= d;
    be <= b;
    rd <= ~w;
    wr_s <= w;
    ev_cmd <= ev;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys_in);
      if (wreq === 1'b0) begin
        got_q = rdat;
        break;
      end
    end
    rd <= 1'b0;
    wr_s <= 1'b0;
    ev_cmd <= 8'h00;
    if (n == 16) begin
      errors++;
      $display("Error at %0t: bus access timed out", $time);
      tally_and_finish();
    end
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] b = 4'h1, input logic [7:0] ev = 8'h0);
    acc(1'b1, a, d, b, ev);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 4'hf, 8'h00);
    check(got_q, exp);
  endtask : rd_chk
  task automatic pulse(input logic [7:0] ev);
    @(posedge clk_sys_in);
    ev_cmd <= ev;
    @(posedge clk_sys_in);
    ev_cmd <= 8'h00;
  endtask : pulse
  // Requests pass two register stages; three cycles covers them
  task automatic req_chk(input logic [1:0] exp);
    repeat (3) @(posedge clk_sys_in);
    check({30'h0, hi_req, lo_req}, {30'h0, exp});
  endtask : req_chk
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd_chk(`OFS_FLAGS_B, 32'h00);
    rd_chk(`OFS_ENABLE_A, 32'h00);
    rd_chk(`OFS_PRIORITY_A, 32'hff);
    rd_chk(`OFS_PRIORITY_B, 32'hdf);
    rd_chk(`OFS_RESET_CAUSE, 32'h1a);
    rd_chk(8'h1c, 32'h00);
    wr(`OFS_ENABLE_B, 32'hff);
    rd_chk(`OFS_ENABLE_B, 32'hdf);
    wr(`OFS_ENABLE_B, 32'h00, 4'he);
    rd_chk(`OFS_ENABLE_B, 32'hdf);
    wr(`OFS_FLAGS_B, 32'hff);
    rd_chk(`OFS_FLAGS_B, 32'hdf);
    wr(`OFS_FLAGS_B, 32'h00);
    wr(`OFS_ENABLE_B, 32'h00);
    wr(`OFS_PRIORITY_B, 32'hff);
    rd_chk(`OFS_PRIORITY_B, 32'hdf);
    wr(`OFS_FLAGS_A, 32'hff);
    rd_chk(`OFS_FLAGS_A, 32'h00);
    $display("Done: register access");
    // Each event sets only its own flag with every enable off
    foreach (bits[i]) begin
      pulse(8'h01 << bits[i]);
      rd_chk(`OFS_FLAGS_B, 32'h1 << bits[i]);
      rd_chk(`OFS_FLAGS_B, 32'h1 << bits[i]);
      wr(`OFS_FLAGS_B, 32'h00);
    end
    for (int m = 0; m < 4; m++) begin
      mode <= periph_irq_pkg::capcmp_mode_t'(m);
      pulse(8'h01);
      rd_chk(`OFS_FLAGS_B, {31'h0, mode == periph_irq_pkg::CAPCMP_CAPTURE});
      wr(`OFS_FLAGS_B, 32'h00);
      pulse(8'h20);
      rd_chk(`OFS_FLAGS_B, {31'h0, mode == periph_irq_pkg::CAPCMP_COMPARE});
      wr(`OFS_FLAGS_B, 32'h00);
    end
    // Clear collides with a timer 3 event: the event must survive
    wr(`OFS_FLAGS_B, 32'h00, 4'h1, 8'h02);
    rd_chk(`OFS_FLAGS_B, 32'h02);
    $display("Done: flags");
    wr(`OFS_ENABLE_B, 32'h02);
    wr(`OFS_PRIORITY_B, 32'h00);
    hi_en <= 1'b1;
    req_chk(2'b00);
    lo_en <= 1'b1;
    req_chk(2'b10);
    wr(`OFS_ENABLE_B, 32'h00);
    req_chk(2'b00);
    wr(`OFS_RESET_CAUSE, 32'h80);
    rd_chk(`OFS_RESET_CAUSE, 32'h9a);
    check({31'h0, lvl_on}, 32'h1);
    wr(`OFS_ENABLE_B, 32'h02);
    req_chk(2'b01);
    lo_en <= 1'b0;
    req_chk(2'b00);
    wr(`OFS_PRIORITY_B, 32'h02);
    req_chk(2'b10);
    hi_en <= 1'b0;
    req_chk(2'b00);
    $display("Done: bank b requests");
    hi_en <= 1'b1;
    lo_en <= 1'b1;
    first_flags <= 8'h41;
    wr(`OFS_ENABLE_B, 32'h00);
    wr(`OFS_PRIORITY_A, 32'hbf);
    wr(`OFS_ENABLE_A, 32'h40);
    req_chk(2'b01);
    wr(`OFS_ENABLE_A, 32'h01);
    req_chk(2'b10);
    rd_chk(`OFS_FLAGS_A, 32'h41);
    $display("Done: bank a requests");
    // Mid-run reset must restore priority a and the switch and drop both requests, with enables still high
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd_chk(`OFS_PRIORITY_A, 32'hff);
    rd_chk(`OFS_RESET_CAUSE, 32'h1a);
    req_chk(2'b00);
    $display("Done: mid-run reset");
    tally_and_finish();
  end
endmodule : periph_irq_flag_enable_priority_test
